// ---- core/pbg_ctrl.sv ----
// Controller that spaces DDR4 commands by bank group and sets preamble modes
// Assumes the device samples cmd outputs each sys_clk edge
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// [R01] Write preamble length follows MR4 bit 12 the controller writes.
// [R02] Read preamble length follows MR4 bit 11 the controller writes.
// [R03] Write and read preamble bits are set independently.
// [R04] Two-clock preamble only requested at 2400 MT/s or faster.
// [R05] Two-clock read preamble forbids column spacing of exactly five.
// [R06] Two-clock write preamble forbids five, or six with write CRC.
// [R07] Primary CWL gains two clocks in two-clock write preamble mode.
// [R08] Write recovery and write-to-read may be one clock longer; the controller adds no clock to WTR_S_CYC or WTR_L_CYC.
// [R09] Preamble training only allowed inside multipurpose register mode.
// [R10] Training entered writing MR4 bit 10 one, left writing zero.
// [R11] Device drives strobes valid and DQ high after training enable.
// [R12] Device holds strobes static until a page 0 register read.
// [R13] Write postamble stays half a clock in both preamble modes.
// [R14] Device keeps read postamble at half a clock.
// [R15] Narrow devices use two bank group bits, x16 uses one.
// [R16] Column commands wait short across groups, long within a group.
// [R17] Each limit except short column spacing uses the larger of clock count and time.
// [R18] Activates wait short across groups, long within a group.
// [R19] Reads after writes wait short or long write-to-read delay.
// [R20] Per group counters of last column, activate and write.
`timescale 1ns/10ps
`default_nettype none
module pbg_ctrl #(
  parameter int NUM_BG = 4,
  parameter bit FAST_BIN = 1'b1,
  parameter bit ALT_CWL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire pbg_pkg::pbg_req_t reqIn,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic wrPre2,
  input wire logic rdPre2,
  input wire logic crcOn,
  input wire logic mprMode,
  input wire logic trainOn,
  output pbg_pkg::pbg_req_t cmdOut,
  output logic trainActive,
  output logic wrPreMode,
  output logic rdPreMode,
  output logic [4:0] cwlUsed
);
  import pbg_pkg::*;
  localparam int BGW = (NUM_BG > 2) ? 2 : 1;
  // ****************************************
  // Per group elapsed counters
  // ****************************************
  logic [CNT_W-1:0] casAge [NUM_BG];
  logic [CNT_W-1:0] actAge [NUM_BG];
  logic [CNT_W-1:0] wrAge [NUM_BG];
  logic [CNT_W-1:0] next_casAge [NUM_BG];
  logic [CNT_W-1:0] next_actAge [NUM_BG];
  logic [CNT_W-1:0] next_wrAge [NUM_BG];
  logic [CNT_W-1:0] lastCas;
  logic [CNT_W-1:0] next_lastCas;
  logic [CNT_W-1:0] needCas;
  logic [CNT_W-1:0] needAct;
  logic [CNT_W-1:0] needWtr;
  logic ok;
  logic issue;
  logic isCas;
  logic modeWrite;
  logic wantW2;
  logic wantR2;
  logic next_trainActive;
  logic next_wrPreMode;
  logic next_rdPreMode;
  pbg_req_t next_cmdOut;
  logic [BGW-1:0] grp;
  logic [CNT_W-1:0] sinceCas;
  assign grp = reqIn.bankGroup[BGW-1:0];  // see [R15]
  assign isCas = (reqIn.cmd == PBG_RD) || (reqIn.cmd == PBG_WR);
  assign wantW2 = wrPre2 && FAST_BIN;  // see [R04]
  assign wantR2 = rdPre2 && FAST_BIN;  // see [R04]
  assign modeWrite = (reqIn.cmd == PBG_MRS) && (reqIn.bankGroup == 2'h1) && (reqIn.bank == 2'h0);

  // ****************************************
  // Spacing checks
  // ****************************************
  always_comb begin
    ok = 1'b1;
    needCas = CNT_W'(CCD_S_CYC);
    needAct = CNT_W'(RRD_S_CYC);
    needWtr = CNT_W'(WTR_S_CYC);
    sinceCas = lastCas;
    for (int g = 0; g < NUM_BG; g++) begin
      needCas = (g == int'(grp)) ? CNT_W'(CCD_L_CYC) : CNT_W'(CCD_S_CYC);  // see [R16] [R17]
      needAct = (g == int'(grp)) ? CNT_W'(RRD_L_CYC) : CNT_W'(RRD_S_CYC);  // see [R18] [R17]
      needWtr = (g == int'(grp)) ? CNT_W'(WTR_L_CYC) : CNT_W'(WTR_S_CYC);  // see [R19] [R08]
      if (isCas && casAge[g] < needCas) begin
        ok = 1'b0;  // see [R20]
      end
      if (reqIn.cmd == PBG_ACT && actAge[g] < needAct) begin
        ok = 1'b0;  // see [R20]
      end
      if (reqIn.cmd == PBG_RD && wrAge[g] < needWtr) begin
        ok = 1'b0;  // see [R19]
      end
    end
    if (isCas && rdPreMode && sinceCas == 6'h05) begin
      ok = 1'b0;  // see [R05]
    end
    if (isCas && wrPreMode && sinceCas == (crcOn ? 6'h06 : 6'h05)) begin
      ok = 1'b0;  // see [R06]
    end
    if (modeWrite && reqIn.addr[MR4_TRAIN_BIT] && !mprMode) begin
      ok = 1'b0;  // see [R09]
    end
  end
  assign reqReady = ok;
  assign issue = reqValid && ok;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_cmdOut = '0;
    next_trainActive = trainActive;
    next_wrPreMode = wrPreMode;
    next_rdPreMode = rdPreMode;
    next_lastCas = (lastCas == CNT_SAT) ? lastCas : lastCas + 6'h01;
    for (int g = 0; g < NUM_BG; g++) begin
      next_casAge[g] = (casAge[g] == CNT_SAT) ? casAge[g] : casAge[g] + 6'h01;
      next_actAge[g] = (actAge[g] == CNT_SAT) ? actAge[g] : actAge[g] + 6'h01;
      next_wrAge[g] = (wrAge[g] == CNT_SAT) ? wrAge[g] : wrAge[g] + 6'h01;
      if (issue && g == int'(grp)) begin
        if (isCas) begin
          next_casAge[g] = 6'h01;
        end
        if (reqIn.cmd == PBG_ACT) begin
          next_actAge[g] = 6'h01;
        end
        if (reqIn.cmd == PBG_WR) begin
          next_wrAge[g] = 6'h01;
        end
      end
    end
    if (issue) begin
      next_cmdOut = reqIn;
      if (isCas) begin
        next_lastCas = 6'h01;
      end
      if (modeWrite) begin
        next_cmdOut.addr[MR4_WPRE_BIT] = wantW2;  // see [R01] [R03] [R13]
        next_cmdOut.addr[MR4_RPRE_BIT] = wantR2;  // see [R02] [R03]
        next_cmdOut.addr[MR4_TRAIN_BIT] = trainOn && mprMode;  // see [R10]
        next_wrPreMode = wantW2;
        next_rdPreMode = wantR2;
        next_trainActive = trainOn && mprMode;  // see [R10]
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmdOut <= '0;
      trainActive <= 1'b0;
      wrPreMode <= 1'b0;
      rdPreMode <= 1'b0;
      lastCas <= CNT_SAT;
      for (int g = 0; g < NUM_BG; g++) begin
        casAge[g] <= CNT_SAT;
        actAge[g] <= CNT_SAT;
        wrAge[g] <= CNT_SAT;
      end
    end else begin
      cmdOut <= next_cmdOut;
      trainActive <= next_trainActive;
      wrPreMode <= next_wrPreMode;
      rdPreMode <= next_rdPreMode;
      lastCas <= next_lastCas;
      for (int g = 0; g < NUM_BG; g++) begin
        casAge[g] <= next_casAge[g];
        actAge[g] <= next_actAge[g];
        wrAge[g] <= next_wrAge[g];
      end
    end
  end

  // Write latency with two extra clocks for primary choice in two-clock mode
  assign cwlUsed = 5'(CWL_CLK) + ((wrPreMode && !ALT_CWL) ? 5'h02 : 5'h00);  // see [R07]
endmodule
`default_nettype wire

// ---- core/pbg_pkg.sv ----
// Package for the DDR4 bank group command spacing controller
// Assumes a command clock equal to the memory clock, one command slot per cycle
package pbg_pkg;
  // ****************************************
  // Mode register 4 field positions
  // ****************************************
  localparam int MR4_TRAIN_BIT = 10;
  localparam int MR4_RPRE_BIT = 11;
  localparam int MR4_WPRE_BIT = 12;
  localparam logic [2:0] MR4_ADDR = 3'h4;
  // ****************************************
  // Memory clock and timing figures
  // ****************************************
  localparam int TCK_PS = 40000;
  localparam int CCD_S_NCK = 4;
  localparam int CCD_L_NCK = 4;
  localparam int CCD_L_PS = 5000;
  localparam int RRD_S_NCK = 4;
  localparam int RRD_S_PS = 3300;
  localparam int RRD_L_NCK = 4;
  localparam int RRD_L_PS = 4900;
  localparam int WTR_S_NCK = 2;
  localparam int WTR_S_PS = 2500;
  localparam int WTR_L_NCK = 4;
  localparam int WTR_L_PS = 7500;
  localparam int CWL_CLK = 12;
  localparam int WBL_HALF = 4;
  // Larger of clock count and time rounded up
  function automatic int maxck(input int nck, input int ps);
    int c;
    c = (ps + TCK_PS - 1) / TCK_PS;
    return (c > nck) ? c : nck;
  endfunction
  localparam int CCD_S_CYC = CCD_S_NCK;
  localparam int CCD_L_CYC = maxck(CCD_L_NCK, CCD_L_PS);
  localparam int RRD_S_CYC = maxck(RRD_S_NCK, RRD_S_PS);
  localparam int RRD_L_CYC = maxck(RRD_L_NCK, RRD_L_PS);
  localparam int WTR_S_CYC = CWL_CLK + WBL_HALF + maxck(WTR_S_NCK, WTR_S_PS);
  localparam int WTR_L_CYC = CWL_CLK + WBL_HALF + maxck(WTR_L_NCK, WTR_L_PS);
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_SAT = 6'h3F;
  // ****************************************
  // Commands
  // ****************************************
  typedef enum logic [2:0] {PBG_NOP, PBG_ACT, PBG_RD, PBG_WR, PBG_MRS, PBG_PRE} pbg_cmd_t;
  typedef struct packed {
    pbg_cmd_t cmd;
    logic [1:0] bankGroup;
    logic [1:0] bank;
    logic [16:0] addr;
  } pbg_req_t;
endpackage

// ---- test/pbg_ctrl_properties.sv ----
// Checker for the bank group spacing controller
// Assumes binding to pbg_ctrl with the default ALT_CWL of 0
`timescale 1ns/10ps
`default_nettype none
module pbg_ctrl_properties (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mprMode,
  input wire logic crcOn,
  input wire pbg_pkg::pbg_req_t cmdOut,
  input wire logic trainActive,
  input wire logic wrPreMode,
  input wire logic rdPreMode,
  input wire logic [4:0] cwlUsed
);
  import pbg_pkg::*;
  wire logic col = cmdOut.cmd inside {PBG_RD, PBG_WR};
  wire logic mr4 = cmdOut.cmd == PBG_MRS && cmdOut.bankGroup == 2'h1 && cmdOut.bank == 2'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Mode and spacing checks
  // ****************************************
  wr_pre_a: assert property (mr4 |=> wrPreMode == $past(cmdOut.addr[12])) else $error("wr mode");
  train_bit_a: assert property (mr4 |=> trainActive == $past(cmdOut.addr[10])) else $error("train");
  train_mpr_a: assert property (mr4 && cmdOut.addr[10] |-> $past(mprMode)) else $error("mpr");
  cwl_pick_a: assert property (cwlUsed == (wrPreMode ? 5'h0E : 5'h0C)) else $error("cwl");
  col_space_a: assert property (col |=> (!col) [*3]) else $error("ccd");
  act_space_a: assert property (cmdOut.cmd == PBG_ACT |=> (cmdOut.cmd != PBG_ACT) [*3]) else $error("rrd");
  rd_gap_a: assert property (rdPreMode && col |-> ##5 !col) else $error("rd gap");
  wr_gap_a: assert property (wrPreMode && crcOn && col |-> ##6 !col) else $error("wr gap");
  wtr_short_a: assert property (cmdOut.cmd == PBG_WR |-> not (##[1:17] cmdOut.cmd == PBG_RD)) else $error("wtr");
endmodule
bind pbg_ctrl pbg_ctrl_properties chk_u (.sys_clk, .sys_rst, .mprMode, .crcOn, .cmdOut, .trainActive,
  .wrPreMode, .rdPreMode, .cwlUsed);
`default_nettype wire

// ---- test/pbg_dev.sv ----
// Device model that keeps the mode register 4 preamble and training bits
// Assumes one command per sys_clk on the controller's cmdOut
`timescale 1ns/10ps
`default_nettype none
module pbg_dev (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire pbg_pkg::pbg_req_t cmd,
  output logic [2:0] mr4Bits
);
  import pbg_pkg::*;
  logic [2:0] next_mr4Bits;
  // Group and bank decode pick MR4; write, read and training bits latch together
  // Training bit stands for the strobe hold and postamble behaviour
  always_comb begin
    next_mr4Bits = mr4Bits;
    if (cmd.cmd == PBG_MRS && cmd.bankGroup == 2'h1 && cmd.bank == 2'h0) begin
      next_mr4Bits = cmd.addr[12:10];
    end
  end
  always_ff @(posedge sys_clk) begin
    mr4Bits <= sys_rst ? 3'h0 : next_mr4Bits;
  end
endmodule
`default_nettype wire

// ---- test/test_pbg_ctrl.sv ----
// Testbench for the bank group spacing controller
// Assumes pbg_ctrl, its checker and the device model are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_pbg_ctrl;
  import pbg_pkg::*;
  logic sys_clk = 1'h0, sys_rst = 1'h1, reqValid = 1'h0, wrPre2 = 1'h0, rdPre2 = 1'h0;
  logic crcOn = 1'h0, mprMode = 1'h0, trainOn = 1'h0, reqReady, trainActive, wrPreMode, rdPreMode;
  logic [4:0] cwlUsed;
  logic [2:0] mr4Bits;
  pbg_req_t reqIn = '0, cmdOut;
  int n_mismatch = 0, tests_run = 0, cyc = 0, lastAcc = 0, g;
  always #20 sys_clk = ~sys_clk;
  always @(negedge sys_clk) cyc++;
  pbg_ctrl dut_u (.sys_clk, .sys_rst, .reqIn, .reqValid, .reqReady, .wrPre2, .rdPre2, .crcOn, .mprMode,
    .trainOn, .cmdOut, .trainActive, .wrPreMode, .rdPreMode, .cwlUsed);
  pbg_dev dev_u (.sys_clk, .sys_rst, .cmd(cmdOut), .mr4Bits);
  function automatic pbg_req_t rq(input pbg_cmd_t c, input logic [1:0] bg);
    return '{c, bg, 2'h0, 17'h0};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rest(input int n);
    reqValid = 1'h0;
    repeat (n) @(negedge sys_clk);
  endtask
  // Offer after hold idle cycles, wait for acceptance, check the spacing from the last one
  task automatic issue(input pbg_req_t r, input int hold, input int exp);
    if (hold > 0) reqValid = 1'h0;
    repeat (hold) @(negedge sys_clk);
    reqIn = r;
    reqValid = 1'h1;
    #1;
    for (int k = 0; k < 40 && reqReady !== 1'h1; k++) @(negedge sys_clk);
    @(posedge sys_clk);
    g = cyc - lastAcc;
    lastAcc = cyc;
    @(negedge sys_clk);
    if (exp > 0) chk(g, exp);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      wrPre2 = i[1];
      rdPre2 = i[0];
      issue(rq(PBG_MRS, 2'h1), 1, 0);
      rest(2);
      chk(mr4Bits, {i[1], i[0], 1'h0});
      chk({wrPreMode, rdPreMode}, i[1:0]);
      chk(cwlUsed, i[1] ? 5'h0E : 5'h0C);
    end
    $display("test modes done");
  endtask
  task automatic t_space;
    issue(rq(PBG_RD, 2'h0), 1, 0);
    issue(rq(PBG_RD, 2'h0), 0, 4);
    issue(rq(PBG_RD, 2'h1), 0, 4);
    issue(rq(PBG_RD, 2'h1), 4, 6);
    crcOn = 1'h1;
    issue(rq(PBG_WR, 2'h0), 0, 4);
    issue(rq(PBG_WR, 2'h2), 5, 7);
    crcOn = 1'h0;
    issue(rq(PBG_RD, 2'h3), 0, 18);
    issue(rq(PBG_WR, 2'h3), 0, 4);
    issue(rq(PBG_RD, 2'h3), 0, 20);
    issue(rq(PBG_ACT, 2'h0), 0, 0);
    issue(rq(PBG_ACT, 2'h1), 0, 4);
    issue(rq(PBG_ACT, 2'h1), 0, 4);
    rest(1);
    $display("test spacing done");
  endtask
  task automatic t_train;
    trainOn = 1'h1;
    reqIn = rq(PBG_MRS, 2'h1);
    reqIn.addr[MR4_TRAIN_BIT] = 1'h1;
    reqValid = 1'h1;
    repeat (8) @(negedge sys_clk);
    chk(reqReady, 1'h0);
    mprMode = 1'h1;
    issue(rq(PBG_MRS, 2'h1), 0, 0);
    rest(2);
    chk({trainActive, mr4Bits[0]}, 2'h3);
    trainOn = 1'h0;
    issue(rq(PBG_MRS, 2'h1), 0, 0);
    rest(2);
    chk({trainActive, mr4Bits[0]}, 2'h0);
    $display("test train done");
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'h0;
    t_modes;
    t_space;
    t_train;
    give_verdict;
  end
  // Span far beyond the hundred or so cycles the tests need
  initial begin
    #80000;
    n_mismatch++;
    give_verdict;
  end
endmodule
`default_nettype wire
